// ---- src/usb_engine_ctrl_status.sv ----
// serial engine control, status, configuration and third address filter registers
//
// Notes on behaviour
// RULE_01 - enable bit 7 lets endpoints 12-15 answer the third address; clear means no effect
// RULE_02 - bits 6:0 of the third address register hold the compared bus address
// RULE_03 - status 7 error and 6 timeout are taken at the end-of-transaction rise
// RULE_04 - status 5 shows the received token was a setup token
// RULE_05 - status 4 shows a start-of-frame pid, valid while end flag is low
// RULE_06 - status 3 shows a valid sync followed by a valid preamble pid
// RULE_07 - status 2 shows clean completion, taken at the end-of-transaction rise
// RULE_08 - zero on both lines for 32 bit times gives bus reset and an event
// RULE_09 - status 0 rises at transaction end, falls when the next one begins
// RULE_10 - control 7 stops engine dma so the controller owns the data path
// RULE_11 - control 6 forces an acknowledge while receiving
// RULE_12 - control 5 tags the next transmit queue byte as the last one
// RULE_13 - control 4 raises a receive overflow event and flushes the receive fifo
// RULE_14 - control 3 makes the engine send a bit-stuff violation
// RULE_15 - control 2 forces the current transaction to end
// RULE_16 - control bits 1 and 0 read the receive tag and transmit ok views
// RULE_17 - firmware keeps control bits 7 to 2 at zero in normal use
// RULE_18 - firmware sets configuration bit 7 for full-speed operation
// RULE_19 - configuration 6 resets the engine; 5 clears the frame number
// RULE_20 - configuration 4 extends the frame count with falls of high bit 2
// RULE_21 - configuration 3 forces suspend, configuration 2 sends resume signalling
// RULE_22 - configuration 1 sets on resume seen while suspended and raises an event
// RULE_23 - address match needs exact seven-bit equality and the enable set
//
// The AHB-Lite register port was left to the implementer.
`timescale 1ns/1ps
module usb_engine_ctrl_status (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  // line pins
  input wire logic usb_dp_in,
  input wire logic usb_dm_in,
  // engine status
  input wire logic eng_error,
  input wire logic eng_timeout,
  input wire logic eng_setup_token,
  input wire logic eng_sof_token,
  input wire logic eng_pre_token,
  input wire logic eng_ack,
  input wire logic eng_transaction_end,
  input wire logic receive_tag_view,
  input wire logic transmit_ok_view,
  input wire logic [10:0] frame_number,
  // token and transmit queue
  input wire logic token_valid,
  input wire logic [6:0] token_addr,
  input wire logic tx_queue_write,
  // engine controls
  output logic endpoint_match,
  output logic engine_dma_inhibit,
  output logic force_receive_acknowledge,
  output logic force_last_byte_tag,
  output logic receive_overflow_event,
  output logic receive_fifo_flush,
  output logic force_transmit_abort,
  output logic force_transaction_end,
  output logic full_speed_select,
  output logic engine_soft_reset,
  output logic engine_suspend_force,
  output logic engine_wake_send,
  output logic pm_reset_event,
  output logic pm_resume_event,
  // frame number
  output logic [7:0] frame_low_byte,
  output logic [7:0] frame_high_byte
);
  import usb_engine_pkg::*;

  bus_phase_e phase_ff;
  logic [31:0] addr_ff;
  logic hreadyout_ff;
  logic [31:0] hrdata_ff;
  logic [7:0] alt3_ff;
  logic [7:2] ctrl_ff;
  logic [7:2] cfg_ff;
  logic err_ff;
  logic timeout_ff;
  logic ack_ff;
  logic setup_ff;
  logic sof_ff;
  logic pre_ff;
  logic end_ff;
  logic match_ff;
  logic tag_ff;
  logic ovfl_prev_ff;
  logic ovfl_event_ff;
  logic resume_seen_ff;
  logic reset_prev_ff;
  logic reset_event_ff;
  logic resume_event_ff;
  logic bus_reset;
  logic k_state;
  logic addr_phase;
  logic end_rise;
  logic wr_alt3;
  logic wr_ctrl;
  logic wr_cfg;
  logic [7:0] status_byte;
  logic [7:0] control_byte;
  logic [7:0] config_byte;
  logic [31:0] nxt_rdata;

  ////////////////////////////////////////////////////////////////////////////
  // submodules

  usb_line_monitor u_line (
    .hclk(hclk),
    .hresetn(hresetn),
    .usb_dp_in(usb_dp_in),
    .usb_dm_in(usb_dm_in),
    .bus_reset_ff(bus_reset),
    .k_state_ff(k_state)
  );

  frame_count_ext u_frame (
    .hclk(hclk),
    .hresetn(hresetn),
    .load(end_rise && eng_sof_token && eng_ack),
    .frame_number(frame_number),
    .clear(cfg_ff[CFG_FRAME_CLEAR]),
    .wide_enable(cfg_ff[CFG_WIDE_FRAME]),
    .frame_low_ff(frame_low_byte),
    .frame_high_ff(frame_high_byte)
  );

  ////////////////////////////////////////////////////////////////////////////
  // ahb-lite slave: writes take no wait state, reads one

  assign addr_phase = hsel && htrans[1] && hready;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      phase_ff <= BUS_IDLE;
      addr_ff <= 32'h0000_0000;
      hreadyout_ff <= 1'b1;
      hrdata_ff <= 32'h0000_0000;
    end else begin
      case (phase_ff)
        BUS_READ: begin
          hrdata_ff <= nxt_rdata;
          hreadyout_ff <= 1'b1;
          phase_ff <= BUS_IDLE;
        end
        default: begin
          if (addr_phase) begin
            addr_ff <= haddr;
            phase_ff <= bus_phase_e'(hwrite ? BUS_WRITE : BUS_READ);
            hreadyout_ff <= hwrite;
          end else begin
            phase_ff <= BUS_IDLE;
          end
        end
      endcase
    end
  end

  assign hreadyout = hreadyout_ff;
  assign hrdata = hrdata_ff;
  assign hresp = 1'b0;

  assign wr_alt3 = (phase_ff == BUS_WRITE) && (addr_ff == ALT3_ADDR);
  assign wr_ctrl = (phase_ff == BUS_WRITE) && (addr_ff == CONTROL_ADDR);
  assign wr_cfg = (phase_ff == BUS_WRITE) && (addr_ff == CONFIG_ADDR);

  assign status_byte = {err_ff, timeout_ff, setup_ff, sof_ff, pre_ff, ack_ff, bus_reset, end_ff};
  assign control_byte = {ctrl_ff, receive_tag_view, transmit_ok_view}; // RULE_16
  assign config_byte = {cfg_ff, resume_seen_ff, bus_reset}; // RULE_08

  // unmapped addresses read as zero
  always_comb begin
    case (addr_ff)
      STATUS_ADDR: nxt_rdata = {24'h000000, status_byte};
      CONTROL_ADDR: nxt_rdata = {24'h000000, control_byte};
      CONFIG_ADDR: nxt_rdata = {24'h000000, config_byte};
      ALT3_ADDR: nxt_rdata = {24'h000000, alt3_ff};
      default: nxt_rdata = 32'h0000_0000;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // writable registers

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      alt3_ff <= ALT3_RESET;
    end else if (wr_alt3) begin
      alt3_ff <= hwdata[7:0]; // RULE_02
    end
  end

  // the last-byte tag clears itself once a queue write has carried it
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_ff <= CONTROL_RESET[7:2];
    end else if (wr_ctrl) begin
      ctrl_ff <= hwdata[7:2];
    end else if (tx_queue_write) begin
      ctrl_ff[CTL_LAST_TAG] <= 1'b0; // RULE_12
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg_ff <= CONFIG_RESET[7:2];
    end else if (wr_cfg) begin
      cfg_ff <= hwdata[7:2];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // status capture

  assign end_rise = eng_transaction_end && !end_ff;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      err_ff <= 1'b0;
      timeout_ff <= 1'b0;
      ack_ff <= 1'b0;
    end else if (end_rise) begin
      err_ff <= eng_error; // RULE_03
      timeout_ff <= eng_timeout; // RULE_03
      ack_ff <= eng_ack; // RULE_07
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      setup_ff <= 1'b0;
      sof_ff <= 1'b0;
      pre_ff <= 1'b0;
      end_ff <= 1'b0;
    end else begin
      setup_ff <= eng_setup_token; // RULE_04
      sof_ff <= eng_sof_token; // RULE_05
      pre_ff <= eng_pre_token; // RULE_06
      end_ff <= eng_transaction_end; // RULE_09
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // third address filter

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      match_ff <= 1'b0;
    end else begin
      match_ff <= token_valid && alt3_ff[ALT3_ENABLE_BIT] && // RULE_01
        (token_addr == alt3_ff[ALT3_ADDR_MSB:0]); // RULE_23
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // forced actions and power events

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tag_ff <= 1'b0;
      ovfl_prev_ff <= 1'b0;
      ovfl_event_ff <= 1'b0;
    end else begin
      tag_ff <= tx_queue_write && ctrl_ff[CTL_LAST_TAG]; // RULE_12
      ovfl_prev_ff <= ctrl_ff[CTL_FORCE_OVFL];
      ovfl_event_ff <= ctrl_ff[CTL_FORCE_OVFL] && !ovfl_prev_ff; // RULE_13
    end
  end

  // resume flag is held only while suspend is forced
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      resume_seen_ff <= 1'b0;
    end else if (!cfg_ff[CFG_SUSPEND]) begin
      resume_seen_ff <= 1'b0;
    end else if (k_state) begin
      resume_seen_ff <= 1'b1; // RULE_22
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      reset_prev_ff <= 1'b0;
      reset_event_ff <= 1'b0;
      resume_event_ff <= 1'b0;
    end else begin
      reset_prev_ff <= bus_reset;
      reset_event_ff <= bus_reset && !reset_prev_ff; // RULE_08
      resume_event_ff <= cfg_ff[CFG_SUSPEND] && k_state && !resume_seen_ff; // RULE_22
    end
  end

  assign endpoint_match = match_ff;
  assign engine_dma_inhibit = ctrl_ff[CTL_DMA_INHIBIT]; // RULE_10
  assign force_receive_acknowledge = ctrl_ff[CTL_FORCE_ACK]; // RULE_11
  assign force_last_byte_tag = tag_ff;
  assign receive_overflow_event = ovfl_event_ff;
  assign receive_fifo_flush = ctrl_ff[CTL_FORCE_OVFL]; // RULE_13
  assign force_transmit_abort = ctrl_ff[CTL_FORCE_ABORT]; // RULE_14
  assign force_transaction_end = ctrl_ff[CTL_FORCE_END]; // RULE_15
  assign full_speed_select = cfg_ff[CFG_FULL_SPEED];
  assign engine_soft_reset = cfg_ff[CFG_SOFT_RESET]; // RULE_19
  assign engine_suspend_force = cfg_ff[CFG_SUSPEND]; // RULE_21
  assign engine_wake_send = cfg_ff[CFG_WAKE_SEND]; // RULE_21
  assign pm_reset_event = reset_event_ff;
  assign pm_resume_event = resume_event_ff;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  property p_alt3_match;
    token_valid && alt3_ff[7] && (token_addr == alt3_ff[6:0]) |=> endpoint_match;
  endproperty
  a_alt3_match: assert property (p_alt3_match) else $error("third address match missed"); // RULE_01

  property p_alt3_off;
    !alt3_ff[7] |=> !endpoint_match;
  endproperty
  a_alt3_off: assert property (p_alt3_off) else $error("disabled filter matched"); // RULE_23

  property p_alt3_write;
    wr_alt3 |=> alt3_ff[6:0] == $past(hwdata[6:0]);
  endproperty
  a_alt3_write: assert property (p_alt3_write) else $error("address not stored"); // RULE_02

  property p_err_capture;
    eng_transaction_end && !end_ff |=> (err_ff == $past(eng_error)) &&
      (timeout_ff == $past(eng_timeout));
  endproperty
  a_err_capture: assert property (p_err_capture) else $error("error not captured"); // RULE_03

  property p_ack_hold;
    !(eng_transaction_end && !end_ff) |=> $stable(ack_ff);
  endproperty
  a_ack_hold: assert property (p_ack_hold) else $error("ack changed outside end rise"); // RULE_07

  property p_end_follow;
    eng_transaction_end != end_ff |=> status_byte[0] == $past(eng_transaction_end);
  endproperty
  a_end_follow: assert property (p_end_follow) else $error("end flag not shown"); // RULE_09

  sequence s_reset_pulse;
    pm_reset_event ##1 !pm_reset_event;
  endsequence
  property p_reset_event;
    $rose(bus_reset) |=> s_reset_pulse;
  endproperty
  a_reset_event: assert property (p_reset_event) else $error("bus reset event wrong"); // RULE_08

  sequence s_ovfl_pulse;
    receive_overflow_event ##1 !receive_overflow_event;
  endsequence
  property p_ovfl_event;
    $rose(ctrl_ff[4]) |=> s_ovfl_pulse;
  endproperty
  a_ovfl_event: assert property (p_ovfl_event) else $error("overflow event wrong"); // RULE_13

  property p_wide_zero;
    !cfg_ff[4] ##1 !cfg_ff[4] |-> frame_high_byte[7:3] == 5'h00;
  endproperty
  a_wide_zero: assert property (p_wide_zero) else $error("frame extension not zero"); // RULE_20

  property p_resume_flag;
    cfg_ff[3] && k_state |=> resume_seen_ff || !cfg_ff[3];
  endproperty
  a_resume_flag: assert property (p_resume_flag) else $error("resume not flagged"); // RULE_22

  property p_read_wait;
    addr_phase && !hwrite && (phase_ff != BUS_READ) |=> !hreadyout ##1 hreadyout;
  endproperty
  a_read_wait: assert property (p_read_wait) else $error("read wait state wrong"); // reads take one wait state

endmodule

// ---- src/usb_engine_pkg.sv ----
// constants for the serial engine control and status registers
package usb_engine_pkg;

  // register indices as printed; the byte address is four times the index
  localparam logic [15:0] STATUS_IDX = 16'h7f93;
  localparam logic [15:0] CONTROL_IDX = 16'h7f94;
  localparam logic [15:0] CONFIG_IDX = 16'h7f98;
  localparam logic [15:0] ALT3_IDX = 16'h7f9f;
  localparam logic [31:0] STATUS_ADDR = {14'h0000, STATUS_IDX, 2'b00};
  localparam logic [31:0] CONTROL_ADDR = {14'h0000, CONTROL_IDX, 2'b00};
  localparam logic [31:0] CONFIG_ADDR = {14'h0000, CONFIG_IDX, 2'b00};
  localparam logic [31:0] ALT3_ADDR = {14'h0000, ALT3_IDX, 2'b00};

  // values after reset
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] CONFIG_RESET = 8'h40;
  localparam logic [7:0] ALT3_RESET = 8'h00;

  // field positions
  localparam int ALT3_ENABLE_BIT = 7;
  localparam int ALT3_ADDR_MSB = 6;
  localparam int CTL_DMA_INHIBIT = 7;
  localparam int CTL_FORCE_ACK = 6;
  localparam int CTL_LAST_TAG = 5;
  localparam int CTL_FORCE_OVFL = 4;
  localparam int CTL_FORCE_ABORT = 3;
  localparam int CTL_FORCE_END = 2;
  localparam int CFG_FULL_SPEED = 7;
  localparam int CFG_SOFT_RESET = 6;
  localparam int CFG_FRAME_CLEAR = 5;
  localparam int CFG_WIDE_FRAME = 4;
  localparam int CFG_SUSPEND = 3;
  localparam int CFG_WAKE_SEND = 2;

  // bus reset: single-ended zero for this many full-speed bit times
  localparam longint unsigned CLK_HZ = 100_000_000;
  localparam longint unsigned FS_BIT_HZ = 12_000_000;
  localparam longint unsigned RESET_BIT_TIMES = 32;
  localparam longint unsigned RESET_CYCLES_L =
    (RESET_BIT_TIMES * CLK_HZ + FS_BIT_HZ - 1) / FS_BIT_HZ;
  localparam logic [9:0] RESET_CYCLES = RESET_CYCLES_L[9:0];

  typedef enum {BUS_IDLE, BUS_WRITE, BUS_READ} bus_phase_e;

endpackage

// ---- src/usb_line_monitor.sv ----
// line watcher: synchronises the data pins, times single-ended zero, sees K state
`timescale 1ns/1ps
module usb_line_monitor (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // line pins
  input wire logic usb_dp_in,
  input wire logic usb_dm_in,
  // line state
  output logic bus_reset_ff,
  output logic k_state_ff
);
  import usb_engine_pkg::*;

  logic [1:0] meta_ff;
  logic [1:0] line_ff;
  logic [9:0] se0_count_ff;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta_ff <= 2'b10;
      line_ff <= 2'b10;
    end else begin
      meta_ff <= {usb_dp_in, usb_dm_in};
      line_ff <= meta_ff;
    end
  end

  // count stops at the threshold so the indication holds while zero persists
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      se0_count_ff <= 10'h000;
      bus_reset_ff <= 1'b0;
    end else if (line_ff != 2'b00) begin
      se0_count_ff <= 10'h000;
      bus_reset_ff <= 1'b0;
    end else begin
      if (se0_count_ff < RESET_CYCLES) begin
        se0_count_ff <= se0_count_ff + 10'h001;
      end
      bus_reset_ff <= (se0_count_ff >= RESET_CYCLES - 10'h001); // RULE_08
    end
  end

  // full-speed K: minus line high, plus line low
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      k_state_ff <= 1'b0;
    end else begin
      k_state_ff <= (line_ff == 2'b01);
    end
  end

endmodule

// ---- src/frame_count_ext.sv ----
// frame number bytes with the optional five-bit extension
`timescale 1ns/1ps
module frame_count_ext (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // control
  input wire logic load,
  input wire logic [10:0] frame_number,
  input wire logic clear,
  input wire logic wide_enable,
  // frame bytes
  output logic [7:0] frame_low_ff,
  output logic [7:0] frame_high_ff
);

  logic [10:0] nxt_frame;
  logic [2:0] high_ff;
  logic [4:0] ext_ff;

  // one process for the frame number and one for the extension, so no bit of the high byte has two writers
  assign frame_high_ff = {ext_ff, high_ff};

  always_comb begin
    nxt_frame = {high_ff, frame_low_ff};
    if (clear) begin
      nxt_frame = 11'h000; // RULE_19
    end else if (load) begin
      nxt_frame = frame_number;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      frame_low_ff <= 8'h00;
      high_ff <= 3'h0;
    end else begin
      frame_low_ff <= nxt_frame[7:0];
      high_ff <= nxt_frame[10:8];
    end
  end

  // extension counts falls of bit 2, held at zero while disabled
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ext_ff <= 5'h00;
    end else if (!wide_enable) begin
      ext_ff <= 5'h00; // RULE_20
    end else if (high_ff[2] && !nxt_frame[10]) begin
      ext_ff <= ext_ff + 5'h01; // RULE_20
    end
  end

endmodule

// ---- dv/usb_host_line.sv ----
// far-side line model: idle J, single-ended zero or K state on the data pins
`timescale 1ns/1ps
module usb_host_line (
  // clock
  input wire logic hclk,
  // requested state: 0 idle J, 1 single-ended zero, 2 K
  input wire logic [1:0] line_cmd,
  // line pins
  output logic usb_dp = 1'b1,
  output logic usb_dm = 1'b0
);
  // pins move just after the edge, like a real transceiver behind a register
  always @(posedge hclk) begin
    usb_dp <= (line_cmd == 2'h0);
    usb_dm <= (line_cmd == 2'h2);
  end
endmodule

// ---- dv/tb.sv ----
// self-checking bench for the serial engine control and status registers
`timescale 1ns/1ps
module tb;
  import usb_engine_pkg::*;
  logic hclk = '0, hresetn = '0, hsel = '0, hwrite = '0, tx_queue_write = '0, token_valid = '0;
  logic [31:0] haddr = '0, hwdata = '0, v;
  logic [1:0] htrans = '0, line_cmd = '0;
  logic [2:0] hsize = 3'h2;
  logic eng_error = '0, eng_timeout = '0, eng_setup_token = '0, eng_sof_token = '0;
  logic eng_pre_token = '0, eng_ack = '0, eng_transaction_end = '0;
  logic receive_tag_view = 1'b1, transmit_ok_view = '0;
  logic [10:0] frame_number = '0;
  logic [6:0] token_addr = '0, a;
  logic [5:0] f;
  logic [15:0] exp_q[$];
  logic [15:0] note;
  logic rd_pend = '0;
  wire logic hready, hreadyout, hresp, usb_dp_in, usb_dm_in;
  wire logic [31:0] hrdata;
  wire logic endpoint_match, engine_dma_inhibit, force_receive_acknowledge, force_last_byte_tag;
  wire logic receive_overflow_event, receive_fifo_flush, force_transmit_abort;
  wire logic force_transaction_end, full_speed_select, engine_soft_reset, engine_suspend_force;
  wire logic engine_wake_send, pm_reset_event, pm_resume_event;
  wire logic [7:0] frame_low_byte, frame_high_byte;
  int seed, err_total = 0, num_checks = 0, base, cyc = 0;
  int n_ovf = 0, n_tag = 0, n_rst = 0, n_res = 0;

  assign hready = hreadyout;
  always #5 hclk = ~hclk;

  usb_engine_ctrl_status dut_u (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata, .hready, .hreadyout, .hrdata, .hresp, .usb_dp_in, .usb_dm_in, .eng_error,
    .eng_timeout, .eng_setup_token, .eng_sof_token, .eng_pre_token, .eng_ack,
    .eng_transaction_end, .receive_tag_view, .transmit_ok_view, .frame_number, .token_valid,
    .token_addr, .tx_queue_write, .endpoint_match, .engine_dma_inhibit,
    .force_receive_acknowledge, .force_last_byte_tag, .receive_overflow_event,
    .receive_fifo_flush, .force_transmit_abort, .force_transaction_end, .full_speed_select,
    .engine_soft_reset, .engine_suspend_force, .engine_wake_send, .pm_reset_event,
    .pm_resume_event, .frame_low_byte, .frame_high_byte);
  usb_host_line host_u (.hclk, .line_cmd, .usb_dp(usb_dp_in), .usb_dm(usb_dm_in));

  //////////////////////////////////////////////////////////////
  task automatic fail(input string s);
    err_total++;
    $display("MISMATCH %0t %s", $time, s);
  endtask
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) fail("byte value");
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    num_checks++;
    if (got !== exp) fail("output level");
  endtask
  task automatic chk_cnt(input int got, input int exp);
    num_checks++;
    if (got != exp) fail("pulse count");
  endtask
  task automatic end_of_test();
    if (err_total == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // one single ahb-lite transfer: hold each phase until ready is sampled high
  task automatic bus(input logic [31:0] ad, input logic w, input logic [7:0] d);
    hsel <= 1'b1;
    haddr <= ad;
    htrans <= 2'h2;
    hwrite <= w;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
  endtask
  task automatic wr(input logic [31:0] ad, input logic [7:0] d);
    bus(ad, 1'b1, d);
  endtask
  task automatic rd(input logic [31:0] ad, input logic [7:0] val, input logic [7:0] m);
    exp_q.push_back({m, val});
    bus(ad, 1'b0, 8'h00);
  endtask
  task automatic match(input logic [6:0] t, input logic e);
    token_addr <= t;
    token_valid <= 1'b1;
    @(posedge hclk);
    token_valid <= 1'b0;
    @(negedge hclk);
    chk_bit(endpoint_match, e);
    @(posedge hclk);
  endtask
  // engine flags, then an end-flag rise; the sampled flags are turned round afterwards
  task automatic transaction_end_flag(input logic [5:0] fl, input logic [10:0] fn);
    eng_transaction_end <= 1'b0;
    {eng_error, eng_timeout, eng_setup_token, eng_sof_token, eng_pre_token, eng_ack} <= fl;
    frame_number <= fn;
    repeat (2) @(posedge hclk);
    eng_transaction_end <= 1'b1;
    repeat (2) @(posedge hclk);
    {eng_error, eng_timeout, eng_ack} <= ~{fl[5], fl[4], fl[0]};
    repeat (2) @(posedge hclk);
  endtask

  //////////////////////////////////////////////////////////////
  // read results and event pulses are watched here
  always @(posedge hclk) begin
    if (rd_pend && hreadyout === 1'b1) begin
      note = exp_q.pop_front();
      chk8(hrdata[7:0] & note[15:8], note[7:0] & note[15:8]);
      chk_bit(|hrdata[31:8], 1'b0);
      chk_bit(hresp, 1'b0);
    end
    if (hreadyout === 1'b1) rd_pend <= hsel & htrans[1] & ~hwrite;
    n_ovf <= n_ovf + int'(receive_overflow_event === 1'b1);
    n_tag <= n_tag + int'(force_last_byte_tag === 1'b1);
    n_rst <= n_rst + int'(pm_reset_event === 1'b1);
    n_res <= n_res + int'(pm_resume_event === 1'b1);
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      err_total++;
      end_of_test();
    end
  end

  initial begin
    seed = 91772;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(CONTROL_ADDR, 8'h02, 8'hff);
    rd(CONFIG_ADDR, CONFIG_RESET, 8'hff);
    rd(ALT3_ADDR, ALT3_RESET, 8'hff);
    rd(32'h0001_fe54, 8'h00, 8'hff);
    chk_bit(engine_soft_reset, 1'b1);
    for (int b = 2; b < 8; b++) begin
      base = n_ovf;
      wr(CONTROL_ADDR, 8'h01 << b);
      repeat (4) @(posedge hclk);
      chk_bit(engine_dma_inhibit, b == 7);
      chk_bit(force_receive_acknowledge, b == 6);
      chk_bit(receive_fifo_flush, b == 4);
      chk_bit(force_transmit_abort, b == 3);
      chk_bit(force_transaction_end, b == 2);
      chk_cnt(n_ovf - base, int'(b == 4));
    end
    base = n_tag;
    wr(CONTROL_ADDR, 8'h20);
    repeat (2) begin
      tx_queue_write <= 1'b1;
      @(posedge hclk);
      tx_queue_write <= 1'b0;
      repeat (2) @(posedge hclk);
    end
    chk_cnt(n_tag - base, 1);
    rd(CONTROL_ADDR, 8'h00, 8'hfc);
    for (int i = 0; i < 6; i++) begin
      v = $random(seed);
      {receive_tag_view, transmit_ok_view} <= v[9:8];
      wr(CONTROL_ADDR, v[7:0]);
      wr(CONFIG_ADDR, v[23:16] | 8'h80);
      wr(ALT3_ADDR, v[31:24]);
      rd(CONTROL_ADDR, {v[7:2], v[9:8]}, 8'hff);
      rd(CONFIG_ADDR, v[23:16] | 8'h80, 8'hfc);
      rd(ALT3_ADDR, v[31:24], 8'hff);
      chk_bit(full_speed_select, 1'b1);
      chk_bit(engine_soft_reset, v[22]);
      chk_bit(engine_suspend_force, v[19]);
      chk_bit(engine_wake_send, v[18]);
    end
    wr(CONTROL_ADDR, 8'h00);
    wr(CONFIG_ADDR, 8'h80);
    a = 7'($random(seed));
    wr(ALT3_ADDR, {1'b1, a});
    match(a, 1'b1);
    match(a ^ 7'h01, 1'b0);
    match(a ^ 7'h40, 1'b0);
    wr(ALT3_ADDR, {1'b0, a});
    match(a, 1'b0);
    for (int i = 0; i < 4; i++) begin
      v = $random(seed);
      f = {v[5:1], ~(v[5] | v[4])};
      transaction_end_flag(f, 11'h000);
      rd(STATUS_ADDR, {f, 2'h1}, 8'hff);
      eng_transaction_end <= 1'b0;
      repeat (2) @(posedge hclk);
      rd(STATUS_ADDR, {f, 2'h0}, 8'hff);
    end
    wr(CONFIG_ADDR, 8'h90);
    transaction_end_flag(6'h05, 11'h400);
    transaction_end_flag(6'h05, 11'h000);
    transaction_end_flag(6'h05, 11'h123);
    chk8(frame_high_byte, 8'h09);
    chk8(frame_low_byte, 8'h23);
    wr(CONFIG_ADDR, 8'hb0);
    repeat (2) @(posedge hclk);
    chk8(frame_high_byte, 8'h08);
    chk8(frame_low_byte, 8'h00);
    wr(CONFIG_ADDR, 8'h80);
    repeat (2) @(posedge hclk);
    chk8(frame_high_byte, 8'h00);
    base = n_rst;
    line_cmd <= 2'h1;
    repeat (250) @(posedge hclk);
    chk_cnt(n_rst - base, 0);
    repeat (40) @(posedge hclk);
    chk_cnt(n_rst - base, 1);
    rd(STATUS_ADDR, 8'h02, 8'h02);
    rd(CONFIG_ADDR, 8'h81, 8'hff);
    line_cmd <= 2'h0;
    repeat (10) @(posedge hclk);
    rd(STATUS_ADDR, 8'h00, 8'h02);
    base = n_res;
    wr(CONFIG_ADDR, 8'h88);
    line_cmd <= 2'h2;
    repeat (8) @(posedge hclk);
    line_cmd <= 2'h0;
    chk_cnt(n_res - base, 1);
    rd(CONFIG_ADDR, 8'h8a, 8'hff);
    wr(CONFIG_ADDR, 8'h84);
    repeat (2) @(posedge hclk);
    chk_bit(engine_wake_send, 1'b1);
    rd(CONFIG_ADDR, 8'h84, 8'hff);
    repeat (4) @(posedge hclk);
    chk_cnt(exp_q.size(), 0);
    end_of_test();
  end
endmodule
